// ---- verilog/abx_exec_unit.sv ----
/*
 * execute stage for add, and, bit set/clear and bit-test-skip instructions.
 * assumes the fetch stage presents one word per cycle with instr_valid_i,
 * and that file reads are combinational (fread_data_i follows fread_addr_o).
 */
// How it works
// - add literal to accumulator, update C DC Z
// - add file register to accumulator, flags C DC Z
// - destination bit zero accumulator, one register
// - and literal into accumulator, Z only
// - and register with accumulator, routed, Z only
// - clear chosen register bit, flags untouched
// - set chosen register bit, flags untouched
// - skip next when tested bit one
// - skip next when tested bit zero
// - fixed 14-bit word field layout
// - opcode values decode as listed
// - one cycle each, skip adds idle slot
// - port self-modify reads pin levels
`timescale 1ns/1ps
`include "abx_defs.svh"

module abx_exec_unit
	import abx_pkg::*;
(
	input  wire logic                    clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic                    instr_valid_i,
	input  wire abx_word_t               instr_i,
	output logic [6:0]                   fread_addr_o,
	input  wire logic [7:0]              fread_data_i,
	input  wire logic                    fread_is_port_i,
	input  wire logic [7:0]              port_pins_i,
	output logic                         fwr_we_o,
	output logic [6:0]                   fwr_addr_o,
	output logic [7:0]                   fwr_data_o,
	output logic                         skip_o,
	output logic [7:0]                   acc_o,
	output logic                         carry_o,
	output logic                         nibble_overflow_bit_o,
	output logic                         zero_o,
	input  wire logic [`ABX_ADDR_W-1:0]  reg_addr_i,
	input  wire logic [7:0]              reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic [7:0]                   reg_rdata_o
);

	// ==========================================================
	// reset release
	logic rst_s1_q;
	logic rst_s2_q;
	logic rst_n;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// ==========================================================
	// port pin synchroniser
	logic [7:0] pins_s1_q;
	logic [7:0] pins_s2_q;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pins_s1_q <= 8'h00;
			pins_s2_q <= 8'h00;
		end else begin
			pins_s1_q <= port_pins_i;
			pins_s2_q <= pins_s1_q;
		end
	end

	// ==========================================================
	// decode
	abx_dec_s dec;

	abx_decode u_dec (
		.instr_i (instr_i),
		.dec_o   (dec)
	);

	function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b);
		logic [4:0] lo;
		logic [8:0] full;
		lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		full = {1'b0, a} + {1'b0, b};
		// {carry, nibble carry, sum}
		return {full[8], lo[`ABX_LOW_NIBBLE_CARRY], full[7:0]};
	endfunction

	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		return 8'h01 << idx;
	endfunction

	// ==========================================================
	// execute
	abx_state_e  state_q, state_d;
	logic [7:0]  acc_q, acc_d;
	logic [2:0]  flags_q, flags_d;
	abx_fwr_s    fwr_q, fwr_d;
	logic        skip_q, skip_d;
	logic [7:0]  rdata_q, rdata_d;
	logic [7:0]  fsrc;
	logic [9:0]  sum;
	logic [7:0]  result;
	logic        exec;
	logic [13:0] instr_shadow_q, instr_shadow_d;

	assign fread_addr_o = dec.faddr;
	// a port read-modify-write sees the pins, not the output latch
	assign fsrc = fread_is_port_i ? pins_s2_q : fread_data_i;
	assign exec = instr_valid_i && (state_q == ABX_ST_RUN);

	always_comb begin
		state_d        = ABX_ST_RUN;
		acc_d          = acc_q;
		flags_d        = flags_q;
		fwr_d          = '0;
		skip_d         = 1'b0;
		rdata_d        = 8'h00;
		instr_shadow_d = instr_shadow_q;
		sum            = add8(acc_q, (dec.kind == ABX_K_ADDL) ? dec.lit : fsrc);
		result         = 8'h00;
		if (state_q == ABX_ST_IDLE) begin
			// discarded word runs as an idle slot
			state_d = instr_valid_i ? ABX_ST_RUN : ABX_ST_IDLE;
		end else if (exec) begin
			instr_shadow_d = instr_i;
			unique case (dec.kind)
				ABX_K_ADDL: begin
					acc_d = sum[7:0];
					flags_d = {sum[7:0] == 8'h00, sum[8], sum[9]};
				end
				ABX_K_ADDW, ABX_K_ANDW: begin
					result = (dec.kind == ABX_K_ADDW) ? sum[7:0] : (acc_q & fsrc);
					if (dec.kind == ABX_K_ADDW) begin
						flags_d = {result == 8'h00, sum[8], sum[9]};
					end else begin
						flags_d[`ABX_FLAG_Z] = (result == 8'h00);
					end
					if (dec.dest_reg) begin
						fwr_d = '{we: 1'b1, addr: dec.faddr, data: result};
					end else begin
						acc_d = result;
					end
				end
				ABX_K_ANDL: begin
					acc_d = acc_q & dec.lit;
					flags_d[`ABX_FLAG_Z] = ((acc_q & dec.lit) == 8'h00);
				end
				ABX_K_CLRB: fwr_d = '{we: 1'b1, addr: dec.faddr,
					data: fsrc & ~bit_mask(dec.bitidx)};
				ABX_K_SETB: fwr_d = '{we: 1'b1, addr: dec.faddr,
					data: fsrc | bit_mask(dec.bitidx)};
				ABX_K_SKO: begin
					skip_d  = |(fread_data_i & bit_mask(dec.bitidx));
					state_d = skip_d ? ABX_ST_IDLE : ABX_ST_RUN;
				end
				ABX_K_SKZ: begin
					skip_d  = ~|(fread_data_i & bit_mask(dec.bitidx));
					state_d = skip_d ? ABX_ST_IDLE : ABX_ST_RUN;
				end
				default: ;
			endcase
		end
		if (reg_wr_i && reg_addr_i == `ABX_REG_ACC) begin
			acc_d = reg_wdata_i;
		end
		if (reg_wr_i && reg_addr_i == `ABX_REG_STATUS) begin
			flags_d = reg_wdata_i[2:0];
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`ABX_REG_INSTR_LO: rdata_d = instr_shadow_q[7:0];
				`ABX_REG_INSTR_HI: rdata_d = {2'h0, instr_shadow_q[13:8]};
				`ABX_REG_ACC:      rdata_d = acc_q;
				`ABX_REG_STATUS:   rdata_d = {5'h00, flags_q};
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q        <= ABX_ST_RUN;
			acc_q          <= `ABX_ACC_RESET;
			flags_q        <= `ABX_STATUS_RESET;
			fwr_q          <= '0;
			skip_q         <= 1'b0;
			rdata_q        <= 8'h00;
			instr_shadow_q <= 14'h0000;
		end else begin
			state_q        <= state_d;
			acc_q          <= acc_d;
			flags_q        <= flags_d;
			fwr_q          <= fwr_d;
			skip_q         <= skip_d;
			rdata_q        <= rdata_d;
			instr_shadow_q <= instr_shadow_d;
		end
	end

	assign acc_o                 = acc_q;
	assign carry_o               = flags_q[`ABX_FLAG_C];
	assign nibble_overflow_bit_o = flags_q[`ABX_FLAG_DC];
	assign zero_o                = flags_q[`ABX_FLAG_Z];
	assign fwr_we_o              = fwr_q.we;
	assign fwr_addr_o            = fwr_q.addr;
	assign fwr_data_o            = fwr_q.data;
	assign skip_o                = skip_q;
	assign reg_rdata_o           = rdata_q;

	// ==========================================================
	// checks
	property p_add_lit;
		@(posedge clk_i) disable iff (!rst_n)
		(exec && dec.kind == ABX_K_ADDL && !reg_wr_i) |=>
			acc_q == 8'(($past(acc_q) + $past(dec.lit)));
	endproperty
	a_add_lit: assert property (p_add_lit) else $error("add literal wrong");

	property p_add_carry;
		@(posedge clk_i) disable iff (!rst_n)
		(exec && dec.kind == ABX_K_ADDW && !reg_wr_i) |=>
			carry_o == (9'($past(acc_q)) + 9'($past(fsrc)) > 9'h0ff);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry wrong");

	property p_dest_reg;
		@(posedge clk_i) disable iff (!rst_n)
		(exec && dec.kind == ABX_K_ANDW && dec.dest_reg) |=>
			fwr_we_o && fwr_data_o == ($past(acc_q) & $past(fsrc));
	endproperty
	a_dest_reg: assert property (p_dest_reg) else $error("and result not written back");

	property p_and_lit_flags;
		@(posedge clk_i) disable iff (!rst_n)
		(exec && dec.kind == ABX_K_ANDL && !reg_wr_i) |=>
			$stable(carry_o) && $stable(nibble_overflow_bit_o) && zero_o == (acc_q == 8'h00);
	endproperty
	a_and_lit_flags: assert property (p_and_lit_flags) else $error("and literal flags");

	property p_and_reg_w;
		@(posedge clk_i) disable iff (!rst_n)
		(exec && dec.kind == ABX_K_ANDW && !dec.dest_reg && !reg_wr_i) |=>
			!fwr_we_o && acc_q == ($past(acc_q) & $past(fsrc));
	endproperty
	a_and_reg_w: assert property (p_and_reg_w) else $error("and to accumulator wrong");

	property p_bit_clear;
		@(posedge clk_i) disable iff (!rst_n)
		(exec && dec.kind == ABX_K_CLRB && !reg_wr_i) |=>
			fwr_we_o && !fwr_data_o[$past(dec.bitidx)] && $stable(flags_q);
	endproperty
	a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

	property p_bit_set;
		@(posedge clk_i) disable iff (!rst_n)
		(exec && dec.kind == ABX_K_SETB && !reg_wr_i) |=>
			fwr_we_o && fwr_data_o[$past(dec.bitidx)] && $stable(flags_q);
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

	property p_skip_one;
		@(posedge clk_i) disable iff (!rst_n)
		(exec && dec.kind == ABX_K_SKO) |=>
			skip_o == $past(fread_data_i[dec.bitidx]);
	endproperty
	a_skip_one: assert property (p_skip_one) else $error("skip when one wrong");

	property p_skip_zero;
		@(posedge clk_i) disable iff (!rst_n)
		(exec && dec.kind == ABX_K_SKZ && !fread_data_i[dec.bitidx]) |=>
			skip_o && state_q == ABX_ST_IDLE ##1 (!fwr_we_o &&
				($past(instr_valid_i) ? state_q == ABX_ST_RUN : state_q == ABX_ST_IDLE));
	endproperty
	a_skip_zero: assert property (p_skip_zero) else $error("skip when zero wrong");

	property p_dest_add;
		@(posedge clk_i) disable iff (!rst_n)
		(exec && dec.kind == ABX_K_ADDW && dec.dest_reg && !reg_wr_i) |=>
			fwr_we_o && fwr_addr_o == $past(dec.faddr) && $stable(acc_q);
	endproperty
	a_dest_add: assert property (p_dest_add) else $error("add result not routed");

	property p_idle_slot;
		@(posedge clk_i) disable iff (!rst_n)
		(state_q == ABX_ST_IDLE && instr_valid_i && !reg_wr_i) |=>
			!fwr_we_o && !skip_o && $stable(acc_q) && $stable(flags_q) && state_q == ABX_ST_RUN;
	endproperty
	a_idle_slot: assert property (p_idle_slot) else $error("dropped word had an effect");

	property p_port_src;
		@(posedge clk_i) disable iff (!rst_n)
		(exec && dec.kind == ABX_K_SETB && fread_is_port_i && !reg_wr_i) |=>
			fwr_data_o == ($past(pins_s2_q) | (8'h01 << $past(dec.bitidx)));
	endproperty
	a_port_src: assert property (p_port_src) else $error("port source not pin levels");

	property p_nibble;
		@(posedge clk_i) disable iff (!rst_n)
		(exec && dec.kind == ABX_K_ADDL && !reg_wr_i) |=> zero_o == (acc_q == 8'h00) &&
			nibble_overflow_bit_o == (5'($past(acc_q[3:0])) + 5'($past(dec.lit[3:0])) > 5'h0f);
	endproperty
	a_nibble: assert property (p_nibble) else $error("nibble carry or zero wrong");

endmodule

// ---- verilog/abx_defs.svh ----
/*
 * constants of the add and bit-test execution unit: opcode fields, flag bits,
 * register-port offsets and reset values.
 * assumes inclusion by bare name from the package and the modules.
 */
`ifndef ABX_DEFS_SVH
`define ABX_DEFS_SVH

// ==========================================================
// instruction fields
`define ABX_OP_ADD_REG      6'h07
`define ABX_OP_AND_REG      6'h05
`define ABX_OP_AND_LIT      6'h39
`define ABX_OP_ADD_LIT_HI   5'h1f
`define ABX_BOP_CLEAR       4'h4
`define ABX_BOP_SET         4'h5
`define ABX_BOP_SKIP_ZERO   4'h6
`define ABX_BOP_SKIP_ONE    4'h7
`define ABX_DEST_BIT        7
`define ABX_LOW_NIBBLE_CARRY 4
`define ABX_F_FADDR         6:0
`define ABX_F_BITIDX        9:7
`define ABX_F_LIT           7:0
`define ABX_F_OP6           13:8
`define ABX_F_OP5           13:9
`define ABX_F_OP4           13:10

// ==========================================================
// control register port (8-bit data)
`define ABX_ADDR_W          2
`define ABX_REG_INSTR_LO    2'h0
`define ABX_REG_INSTR_HI    2'h1
`define ABX_REG_ACC         2'h2
`define ABX_REG_STATUS      2'h3
`define ABX_FLAG_C          0
`define ABX_FLAG_DC         1
`define ABX_FLAG_Z          2
`define ABX_ACC_RESET       8'h00
`define ABX_STATUS_RESET    3'h0

`endif

// ---- verilog/abx_pkg.sv ----
/*
 * types shared by the execution unit files.
 * assumes abx_defs.svh is on the include path.
 */
`include "abx_defs.svh"

package abx_pkg;

	typedef logic [13:0] abx_word_t;

	typedef enum logic [3:0] {
		ABX_K_NONE   = 4'h0,
		ABX_K_ADDW   = 4'h1,
		ABX_K_ANDW   = 4'h2,
		ABX_K_CLRB   = 4'h3,
		ABX_K_SETB   = 4'h4,
		ABX_K_SKZ    = 4'h5,
		ABX_K_SKO    = 4'h6,
		ABX_K_ADDL   = 4'h7,
		ABX_K_ANDL   = 4'h8
	} abx_kind_e;

	typedef struct packed {
		abx_kind_e   kind;
		logic        dest_reg;
		logic [6:0]  faddr;
		logic [2:0]  bitidx;
		logic [7:0]  lit;
	} abx_dec_s;

	typedef struct packed {
		logic        we;
		logic [6:0]  addr;
		logic [7:0]  data;
	} abx_fwr_s;

	typedef enum logic [0:0] {
		ABX_ST_RUN  = 1'b0,
		ABX_ST_IDLE = 1'b1
	} abx_state_e;

endpackage

// ---- verilog/abx_decode.sv ----
/*
 * combinational decoder of one 14-bit instruction word into kind and fields.
 * assumes the word is stable for the whole execute cycle.
 */
`timescale 1ns/1ps
`include "abx_defs.svh"

module abx_decode
	import abx_pkg::*;
(
	input  wire abx_word_t instr_i,
	output abx_dec_s       dec_o
);

	always_comb begin
		dec_o.dest_reg = instr_i[`ABX_DEST_BIT];
		dec_o.faddr    = instr_i[`ABX_F_FADDR];
		dec_o.bitidx   = instr_i[`ABX_F_BITIDX];
		dec_o.lit      = instr_i[`ABX_F_LIT];
		dec_o.kind     = ABX_K_NONE;
		if (instr_i[`ABX_F_OP6] == `ABX_OP_ADD_REG) begin
			dec_o.kind = ABX_K_ADDW;
		end else if (instr_i[`ABX_F_OP6] == `ABX_OP_AND_REG) begin
			dec_o.kind = ABX_K_ANDW;
		end else if (instr_i[`ABX_F_OP5] == `ABX_OP_ADD_LIT_HI) begin
			dec_o.kind = ABX_K_ADDL;
		end else if (instr_i[`ABX_F_OP6] == `ABX_OP_AND_LIT) begin
			dec_o.kind = ABX_K_ANDL;
		end else begin
			unique case (instr_i[`ABX_F_OP4])
				`ABX_BOP_CLEAR:     dec_o.kind = ABX_K_CLRB;
				`ABX_BOP_SET:       dec_o.kind = ABX_K_SETB;
				`ABX_BOP_SKIP_ZERO: dec_o.kind = ABX_K_SKZ;
				`ABX_BOP_SKIP_ONE:  dec_o.kind = ABX_K_SKO;
				default:            dec_o.kind = ABX_K_NONE;
			endcase
		end
	end

endmodule

// ---- verif/abx_file_model.sv ----
/*
 * file register space seen by the execution unit: 128 bytes, combinational
 * read, write on the clock edge that follows the unit's write pulse.
 * assumes one clock shared with the unit; the bench presets cells directly.
 */
`timescale 1ns/1ps

module abx_file_model #(
	parameter logic [6:0] PORT_ADDR = 7'h05
) (
	input  wire logic       clk_i,
	input  wire logic [6:0] rd_addr_i,
	output logic [7:0]      rd_data_o,
	output logic            is_port_o,
	input  wire logic       we_i,
	input  wire logic [6:0] wr_addr_i,
	input  wire logic [7:0] wr_data_i
);
	// ==========================================================
	// storage
	logic [7:0] mem_q [128];

	initial foreach (mem_q[i]) mem_q[i] = 8'h00;
	assign rd_data_o = mem_q[rd_addr_i];
	// one cell stands for an i/o port latch
	assign is_port_o = (rd_addr_i == PORT_ADDR);
	always @(posedge clk_i) begin
		if (we_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end
endmodule

// ---- verif/add_and_bit_test_exec_unit_tb_top.sv ----
/*
 * self-checking bench of the execution unit: reset check, table of single
 * instructions, then skip, port-pin, register-port and mid-run reset cases.
 * assumes the file model and the design package are compiled first.
 */
`timescale 1ns/1ps

module add_and_bit_test_exec_unit_tb_top;
	import abx_pkg::*;

	typedef struct packed {
		abx_word_t  w;
		logic [7:0] fv;
		logic [7:0] a0;
		logic [2:0] s0;
		logic [7:0] ea;
		logic [2:0] es;
		logic       ewe;
		logic [7:0] ed;
	} abx_row_s;

	// ==========================================================
	// signals
	logic       clk, rst_n, vld, rwr, rrd;
	abx_word_t  instr;
	logic [1:0] ra;
	logic [7:0] rwd, pins, frd, fwd, acc, rdat, d;
	logic [6:0] fra, fwa;
	logic       fport, we, skip, c, dc, z;
	int         n_errors, cmp_count;

	// flags column is {z, dc, c}
	abx_row_s rows [12] = '{
		'{14'h3e01, 8'h00, 8'h0f, 3'h0, 8'h10, 3'h2, 1'b0, 8'h00},
		'{14'h3f01, 8'h00, 8'hff, 3'h0, 8'h00, 3'h7, 1'b0, 8'h00},
		'{14'h0720, 8'h80, 8'h80, 3'h0, 8'h00, 3'h5, 1'b0, 8'h00},
		'{14'h07a0, 8'h19, 8'h08, 3'h0, 8'h08, 3'h2, 1'b1, 8'h21},
		'{14'h390f, 8'h00, 8'hf0, 3'h3, 8'h00, 3'h7, 1'b0, 8'h00},
		'{14'h0520, 8'h3c, 8'h0f, 3'h7, 8'h0c, 3'h3, 1'b0, 8'h00},
		'{14'h05a0, 8'h3c, 8'hc3, 3'h0, 8'hc3, 3'h4, 1'b1, 8'h00},
		'{14'h13a0, 8'hff, 8'h55, 3'h7, 8'h55, 3'h7, 1'b1, 8'h7f},
		'{14'h1420, 8'h00, 8'h55, 3'h0, 8'h55, 3'h0, 1'b1, 8'h01},
		'{14'h18a0, 8'h02, 8'h55, 3'h5, 8'h55, 3'h5, 1'b0, 8'h00},
		'{14'h1d20, 8'hfb, 8'h55, 3'h2, 8'h55, 3'h2, 1'b0, 8'h00},
		'{14'h0020, 8'h12, 8'h34, 3'h5, 8'h34, 3'h5, 1'b0, 8'h00}
	};

	abx_exec_unit u_abx_exec_unit (
		.clk_i(clk), .rst_n_i(rst_n), .instr_valid_i(vld), .instr_i(instr),
		.fread_addr_o(fra), .fread_data_i(frd), .fread_is_port_i(fport),
		.port_pins_i(pins), .fwr_we_o(we), .fwr_addr_o(fwa), .fwr_data_o(fwd),
		.skip_o(skip), .acc_o(acc), .carry_o(c), .nibble_overflow_bit_o(dc),
		.zero_o(z), .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rwr),
		.reg_rd_i(rrd), .reg_rdata_o(rdat)
	);

	abx_file_model u_abx_file_model (
		.clk_i(clk), .rd_addr_i(fra), .rd_data_o(frd), .is_port_o(fport),
		.we_i(we), .wr_addr_i(fwa), .wr_data_i(fwd)
	);

	// ==========================================================
	// tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// results of the word are sampled just after the edge that takes it
	task automatic exec(input abx_word_t w);
		@(posedge clk);
		vld <= 1'b1;
		instr <= w;
		@(posedge clk);
		vld <= 1'b0;
		#1;
	endtask

	task automatic reg_w(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk);
		rwr <= 1'b1;
		ra <= a;
		rwd <= v;
		@(posedge clk);
		rwr <= 1'b0;
	endtask

	task automatic reg_r(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk);
		rrd <= 1'b1;
		ra <= a;
		@(posedge clk);
		rrd <= 1'b0;
		#1;
		v = rdat;
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// whole run is about 120 cycles
	initial begin
		#50000;
		n_errors++;
		results();
	end

	// ==========================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		{vld, rwr, rrd, ra, rwd} = '0;
		instr = 14'h0000;
		pins = 8'h0f;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk({acc, z, dc, c, we, skip}, 16'h0000);
		reg_r(2'h2, d);
		chk(d, 8'h00);
		$display("reset test done");
		foreach (rows[i]) begin
			reg_w(2'h2, rows[i].a0);
			reg_w(2'h3, {5'h00, rows[i].s0});
			u_abx_file_model.mem_q[7'h20] = rows[i].fv;
			exec(rows[i].w);
			chk(acc, rows[i].ea);
			chk({z, dc, c}, rows[i].es);
			chk({we, skip}, {rows[i].ewe, 1'b0});
			if (rows[i].ewe) begin
				chk({fwa, fwd}, {7'h20, rows[i].ed});
			end
			$display("row %0d done", i);
		end
		// unknown word in the last row left the preset flags alone
		reg_r(2'h3, d);
		chk(d, 8'h05);
		// true test drops the next valid word, then execution resumes
		for (int j = 0; j < 2; j++) begin
			reg_w(2'h2, 8'h10);
			u_abx_file_model.mem_q[7'h20] = j ? 8'h04 : 8'hfb;
			exec(j ? 14'h1d20 : 14'h1920);
			chk(skip, 1'b1);
			exec(14'h3e01);
			chk({acc, skip}, {8'h10, 1'b0});
			exec(14'h3e01);
			chk(acc, 8'h11);
			$display("skip test %0d done", j);
		end
		// port latch all ones, pins read low nibble only
		u_abx_file_model.mem_q[7'h05] = 8'hff;
		exec(14'h1785);
		chk({we, fwa, fwd}, {1'b1, 7'h05, 8'h8f});
		reg_r(2'h0, d);
		chk(d, 8'h85);
		reg_r(2'h1, d);
		chk(d, 8'h17);
		$display("port test done");
		// reset while in the idle slot: the first word after release must run
		reg_w(2'h2, 8'h33);
		u_abx_file_model.mem_q[7'h20] = 8'hfb;
		exec(14'h1920);
		chk(skip, 1'b1);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk({acc, z, dc, c, we, skip}, 16'h0000);
		exec(14'h3e05);
		chk(acc, 8'h05);
		$display("mid-run reset test done");
		results();
	end
endmodule
